//--- logic/otpcb_bank.sv
// Threshold configuration bank: fuse load at power-up, override writes, fuse burn control
`timescale 1ns/1ns

module otpcb_bank
  import otpcb_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            clk_en,
  input  wire otpcb_req_t      req,
  output logic [7:0]           reg_rdata_q,
  output logic                 reg_rvalid_q,
  input  wire logic            fuse_prog_req,
  input  wire logic [7:0]      fuse_prog_addr,
  input  wire otpcb_fuse_row_t fuse_row,
  output logic [7:0]           fuse_row_addr_q,
  output otpcb_burn_t          burn_q,
  output logic                 prog_busy_q,
  output logic                 prog_refused_q,
  output logic                 fuse_locked_q,
  output logic                 load_done_q,
  input  wire logic            overtemp,
  output logic                 shutdown_q,
  output logic                 supply_cut_q,
  output logic [THR_WIDTH-1:0] battery_over_code_q,
  output logic [THR_WIDTH-1:0] battery_under_code_q,
  output logic [THR_WIDTH-1:0] ignition_on_code_q
);

  otpcb_state_t st_q;
  logic [1:0]   load_idx_q;
  otpcb_slot_t  wr_slot;
  otpcb_slot_t  rd_slot;
  otpcb_slot_t  prog_slot;
  logic         lock_field_q;
  logic         prog_go;
  logic         burn_done;
  logic [7:0]   image [SLOT_COUNT];
  logic [SLOT_COUNT-1:0] ld_en;
  logic [SLOT_COUNT-1:0] wr_en;
  logic [31:0]  burn_len_q;

  assign wr_slot   = slot_of(req.addr);
  assign rd_slot   = slot_of(req.addr);
  assign prog_slot = slot_of(fuse_prog_addr);

  // Burns start only from idle, so a second burn cannot cut the first short
  assign prog_go = (st_q == ST_IDLE) && fuse_prog_req && prog_slot.hit
                   && !fuse_locked_q;

  always_comb begin
    for (int i = 0; i < SLOT_COUNT; i++) begin
      ld_en[i] = clk_en && (st_q == ST_LOAD) && (load_idx_q == i[1:0]);
      wr_en[i] = clk_en && load_done_q && req.wr && wr_slot.hit
                 && (wr_slot.idx == i[1:0]);
    end
  end

  // Reserved bits never stored and always read as zero
  assign image[SLOT_OVER]  = {4'h0, battery_over_code_q};
  assign image[SLOT_UNDER] = {4'h0, battery_under_code_q};
  assign image[SLOT_IGN]   = {4'h0, ignition_on_code_q};
  assign image[SLOT_LOCK]  = {4'h0, lock_field_q, 3'h0};

  otpcb_reg_slot #(
    .WIDTH     (THR_WIDTH),
    .RESET_VAL (OVER_RESET[THR_WIDTH-1:0])
  ) u_over (
    .clock     (clock),
    .reset     (reset),
    .load_en   (ld_en[SLOT_OVER]),
    .load_prog (fuse_row.programmed),
    .load_val  (fuse_row.data[THR_LSB +: THR_WIDTH]),
    .wr_en     (wr_en[SLOT_OVER]),
    .wr_val    (req.wdata[THR_LSB +: THR_WIDTH]),
    .value_q   (battery_over_code_q)
  );

  otpcb_reg_slot #(
    .WIDTH     (THR_WIDTH),
    .RESET_VAL (UNDER_RESET[THR_WIDTH-1:0])
  ) u_under (
    .clock     (clock),
    .reset     (reset),
    .load_en   (ld_en[SLOT_UNDER]),
    .load_prog (fuse_row.programmed),
    .load_val  (fuse_row.data[THR_LSB +: THR_WIDTH]),
    .wr_en     (wr_en[SLOT_UNDER]),
    .wr_val    (req.wdata[THR_LSB +: THR_WIDTH]),
    .value_q   (battery_under_code_q)
  );

  otpcb_reg_slot #(
    .WIDTH     (THR_WIDTH),
    .RESET_VAL (IGN_RESET[THR_WIDTH-1:0])
  ) u_ign (
    .clock     (clock),
    .reset     (reset),
    .load_en   (ld_en[SLOT_IGN]),
    .load_prog (fuse_row.programmed),
    .load_val  (fuse_row.data[THR_LSB +: THR_WIDTH]),
    .wr_en     (wr_en[SLOT_IGN]),
    .wr_val    (req.wdata[THR_LSB +: THR_WIDTH]),
    .value_q   (ignition_on_code_q)
  );

  otpcb_reg_slot #(
    .WIDTH     (1),
    .RESET_VAL (LOCK_RESET[LOCK_BIT])
  ) u_lock (
    .clock     (clock),
    .reset     (reset),
    .load_en   (ld_en[SLOT_LOCK]),
    .load_prog (fuse_row.programmed),
    .load_val  (fuse_row.data[LOCK_BIT]),
    .wr_en     (wr_en[SLOT_LOCK]),
    .wr_val    (req.wdata[LOCK_BIT]),
    .value_q   (lock_field_q)
  );

  otpcb_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clock  (clock),
    .reset  (reset),
    .clk_en (clk_en),
    .start  (prog_go),
    .done   (burn_done)
  );

  // Power-up walk over the fuse rows, one slot per enabled cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_q            <= ST_LOAD;
      load_idx_q      <= SLOT_OVER;
      fuse_row_addr_q <= ADDR_OVER;
      load_done_q     <= 1'b0;
    end else if (clk_en) begin
      case (st_q)
        ST_LOAD: begin
          load_idx_q      <= load_idx_q + 2'h1;
          fuse_row_addr_q <= slot_addr(load_idx_q + 2'h1);
          if (load_idx_q == SLOT_LOCK) begin
            st_q        <= ST_IDLE;
            load_done_q <= 1'b1;
          end
        end
        ST_IDLE: begin
          if (prog_go) begin
            st_q <= ST_BURN;
          end
        end
        ST_BURN: begin
          if (burn_done) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Burn command toward the fuse array: the value in effect is what gets fused
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      burn_q      <= '0;
      prog_busy_q <= 1'b0;
    end else if (clk_en) begin
      if (prog_go) begin
        burn_q.en   <= 1'b1;
        burn_q.addr <= fuse_prog_addr;
        burn_q.data <= image[prog_slot.idx];
        prog_busy_q <= 1'b1;
      end else if (burn_done) begin
        burn_q.en   <= 1'b0;
        prog_busy_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prog_refused_q <= 1'b0;
    end else if (clk_en) begin
      prog_refused_q <= fuse_prog_req && !prog_go;
    end
  end

  // Lockout holds only once the bit itself sits in fuses
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      fuse_locked_q <= 1'b0;
    end else if (clk_en) begin
      if (ld_en[SLOT_LOCK] && fuse_row.programmed && fuse_row.data[LOCK_BIT]) begin
        fuse_locked_q <= 1'b1;
      end else if (burn_done && (burn_q.addr == ADDR_LOCK) && burn_q.data[LOCK_BIT]) begin
        fuse_locked_q <= 1'b1;
      end
    end
  end

  // Reads before the fuse load finishes are dropped; their values are not yet valid
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      reg_rvalid_q <= 1'b0;
      reg_rdata_q  <= 8'h00;
    end else if (clk_en) begin
      reg_rvalid_q <= req.rd && load_done_q;
      if (req.rd && load_done_q) begin
        reg_rdata_q <= rd_slot.hit ? image[rd_slot.idx] : 8'h00;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      shutdown_q   <= 1'b0;
      supply_cut_q <= 1'b0;
    end else if (clk_en) begin
      shutdown_q   <= overtemp;
      supply_cut_q <= overtemp;
    end
  end

  // Length of the burn pulse, for checking only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      burn_len_q <= 32'h0000_0000;
    end else if (clk_en) begin
      burn_len_q <= burn_q.en ? burn_len_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  a_burn_length: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && $fell(burn_q.en)) |-> (burn_len_q == 32'(PROG_CYCLES))
  ) else $error("burn pulse length differs from the burn time");

  a_busy_refuse: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && prog_busy_q && fuse_prog_req)
      |=> (prog_refused_q && !$rose(burn_q.en) && $stable(burn_q.addr))
  ) else $error("burn request during a burn was not refused");

  a_lock_refuse: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && fuse_locked_q && fuse_prog_req && !prog_busy_q)
      |=> (prog_refused_q && !burn_q.en)
  ) else $error("burn accepted while fuses locked");

  a_same_address: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && load_done_q && req.wr && !req.rd && req.addr == ADDR_IGN)
      ##1 (clk_en && req.rd && !req.wr && req.addr == ADDR_IGN)
      |=> (reg_rvalid_q && reg_rdata_q == {4'h0, $past(req.wdata[3:0], 2)})
  ) else $error("read at the written address did not return the write");

  a_reserved_zero: assert property (
    @(posedge clock) disable iff (reset)
    reg_rvalid_q |-> (reg_rdata_q[7:4] == 4'h0)
  ) else $error("reserved bits read nonzero");

  a_load_finish: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && st_q == ST_LOAD && load_idx_q == SLOT_LOCK)
      |=> (load_done_q && st_q == ST_IDLE)
  ) else $error("fuse load did not finish after the last row");

  a_over_default: assert property (
    @(posedge clock) disable iff (reset)
    (ld_en[SLOT_OVER] && !fuse_row.programmed)
      |=> (battery_over_code_q == OVER_RESET[THR_WIDTH-1:0])
  ) else $error("unfused overvoltage code not factory value");

  a_ign_fused: assert property (
    @(posedge clock) disable iff (reset)
    (ld_en[SLOT_IGN] && fuse_row.programmed)
      |=> (ignition_on_code_q == $past(fuse_row.data[THR_WIDTH-1:0]))
  ) else $error("fused ignition code not loaded");

  a_under_override: assert property (
    @(posedge clock) disable iff (reset)
    wr_en[SLOT_UNDER] |=> (battery_under_code_q == $past(req.wdata[THR_WIDTH-1:0]))
  ) else $error("undervoltage override write not taken");

  a_thermal_cut: assert property (
    @(posedge clock) disable iff (reset)
    (clk_en && overtemp) ##1 (clk_en && !overtemp)
      |-> (shutdown_q && supply_cut_q) ##1 (!shutdown_q && !supply_cut_q)
  ) else $error("thermal shutdown did not follow the detector");

endmodule // otpcb_bank

//--- shared/otpcb_pkg.sv
// Package: register map, field layout, timing and carrier types of the threshold bank
package otpcb_pkg;

  // Register addresses, one address serves both reads and writes
  localparam logic [7:0] ADDR_OVER  = 8'h01;
  localparam logic [7:0] ADDR_UNDER = 8'h02;
  localparam logic [7:0] ADDR_IGN   = 8'h03;
  localparam logic [7:0] ADDR_LOCK  = 8'h15;

  // Field layout
  localparam int unsigned THR_LSB   = 0;
  localparam int unsigned THR_WIDTH = 4;
  localparam int unsigned LOCK_BIT  = 3;

  // Factory power-up values
  localparam logic [7:0] OVER_RESET  = 8'h00;
  localparam logic [7:0] UNDER_RESET = 8'h00;
  localparam logic [7:0] IGN_RESET   = 8'h00;
  localparam logic [7:0] LOCK_RESET  = 8'h00;

  // Fuse burn time per register
  localparam int unsigned CLOCK_PERIOD_NS = 4;
  localparam int unsigned PROG_TIME_MS    = 12;
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_MS * 1000000 / CLOCK_PERIOD_NS;

  // Storage slots, in power-up load order
  localparam int unsigned SLOT_COUNT = 4;
  localparam logic [1:0]  SLOT_OVER  = 2'h0;
  localparam logic [1:0]  SLOT_UNDER = 2'h1;
  localparam logic [1:0]  SLOT_IGN   = 2'h2;
  localparam logic [1:0]  SLOT_LOCK  = 2'h3;

  typedef enum logic [1:0] {ST_LOAD, ST_IDLE, ST_BURN} otpcb_state_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } otpcb_req_t;

  typedef struct packed {
    logic       programmed;
    logic [7:0] data;
  } otpcb_fuse_row_t;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } otpcb_burn_t;

  typedef struct packed {
    logic       hit;
    logic [1:0] idx;
  } otpcb_slot_t;

  function automatic otpcb_slot_t slot_of(input logic [7:0] addr);
    otpcb_slot_t s;
    s.hit = 1'b1;
    s.idx = SLOT_OVER;
    if (addr == ADDR_OVER) begin
      s.idx = SLOT_OVER;
    end else if (addr == ADDR_UNDER) begin
      s.idx = SLOT_UNDER;
    end else if (addr == ADDR_IGN) begin
      s.idx = SLOT_IGN;
    end else if (addr == ADDR_LOCK) begin
      s.idx = SLOT_LOCK;
    end else begin
      s.hit = 1'b0;
    end
    return s;
  endfunction

  function automatic logic [7:0] slot_addr(input logic [1:0] idx);
    logic [7:0] a;
    a = ADDR_OVER;
    if (idx == SLOT_UNDER) begin
      a = ADDR_UNDER;
    end else if (idx == SLOT_IGN) begin
      a = ADDR_IGN;
    end else if (idx == SLOT_LOCK) begin
      a = ADDR_LOCK;
    end
    return a;
  endfunction

endpackage

//--- logic/otpcb_prog_timer.sv
// Burn duration timer: one done pulse CYCLES enabled cycles after start
`timescale 1ns/1ns

module otpcb_prog_timer
  import otpcb_pkg::*;
#(
  parameter int unsigned CYCLES = PROG_CYCLES_DEF
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      done
);

  localparam int unsigned CW = $clog2(CYCLES + 1);

  logic          busy_q;
  logic [CW-1:0] cnt_q;

  assign done = clk_en && busy_q && (cnt_q == CW'(CYCLES - 1));

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (clk_en) begin
      if (start) begin
        busy_q <= 1'b1;
        cnt_q  <= '0;
      end else if (done) begin
        busy_q <= 1'b0;
      end else if (busy_q) begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

endmodule // otpcb_prog_timer

//--- logic/otpcb_reg_slot.sv
// One settable register field: factory value, fuse value at power-up, run-time override
`timescale 1ns/1ns

module otpcb_reg_slot
  import otpcb_pkg::*;
#(
  parameter int unsigned      WIDTH     = THR_WIDTH,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             load_en,
  input  wire logic             load_prog,
  input  wire logic [WIDTH-1:0] load_val,
  input  wire logic             wr_en,
  input  wire logic [WIDTH-1:0] wr_val,
  output logic [WIDTH-1:0]      value_q
);

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      // Power cycle drops any override
      value_q <= RESET_VAL;
    end else if (load_en) begin
      value_q <= load_prog ? load_val : RESET_VAL;
    end else if (wr_en) begin
      value_q <= wr_val;
    end
  end

endmodule // otpcb_reg_slot

//--- testbench/otpcb_fuse_model.sv
// Fuse array stand-in: rows survive power cycles and are burned only by complete burns
`timescale 1ns/1ns

module otpcb_fuse_model
  import otpcb_pkg::*;
#(
  parameter int unsigned CYCLES = 6
) (
  input  wire logic        clock,
  input  wire logic [7:0]  fuse_row_addr_q,
  input  wire otpcb_burn_t burn_q,
  output otpcb_fuse_row_t  fuse_row
);
  // No reset input: fuse contents must outlive every power cycle
  logic [7:0]  row_bits [256];
  logic        row_set  [256];
  int unsigned burn_len;
  logic        en_prev;

  initial begin
    for (int i = 0; i < 256; i++) begin
      row_bits[i] = 8'h00;
      row_set[i]  = 1'b0;
    end
    burn_len = 0;
    en_prev  = 1'b0;
  end

  // Unblown rows report not programmed, so the factory value applies
  assign fuse_row = {row_set[fuse_row_addr_q], row_bits[fuse_row_addr_q]};

  // A burn cut short before its full time leaves the row untouched
  always @(posedge clock) begin
    if (burn_q.en) begin
      burn_len <= burn_len + 1;
    end else begin
      if (en_prev && burn_len == CYCLES) begin
        row_bits[burn_q.addr] <= row_bits[burn_q.addr] | burn_q.data;
        row_set[burn_q.addr]  <= 1'b1;
      end
      burn_len <= 0;
    end
    en_prev <= burn_q.en;
  end
endmodule // otpcb_fuse_model

//--- testbench/otp_threshold_config_bank_bench.sv
// Self-checking bench: register access, fuse burns, lockout, power cycles, thermal shutdown
`timescale 1ns/1ns

module otp_threshold_config_bank_bench
  import otpcb_pkg::*;
;
  // Short burn so the run stays small
  localparam int unsigned PC = 6;

  logic            clock;
  logic            reset;
  logic            clk_en;
  otpcb_req_t      req;
  logic [7:0]      reg_rdata_q;
  logic            reg_rvalid_q;
  logic            fuse_prog_req;
  logic [7:0]      fuse_prog_addr;
  otpcb_fuse_row_t fuse_row;
  logic [7:0]      fuse_row_addr_q;
  otpcb_burn_t     burn_q;
  logic            prog_busy_q;
  logic            prog_refused_q;
  logic            fuse_locked_q;
  logic            load_done_q;
  logic            overtemp;
  logic            shutdown_q;
  logic            supply_cut_q;
  logic [3:0]      over_code;
  logic [3:0]      under_code;
  logic [3:0]      ign_code;
  int              error_cnt = 0;
  int              tests_run = 0;

  otpcb_bank #(.PROG_CYCLES(PC)) dut_u (
    .clock(clock), .reset(reset), .clk_en(clk_en), .req(req),
    .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .fuse_prog_req(fuse_prog_req), .fuse_prog_addr(fuse_prog_addr),
    .fuse_row(fuse_row), .fuse_row_addr_q(fuse_row_addr_q), .burn_q(burn_q),
    .prog_busy_q(prog_busy_q), .prog_refused_q(prog_refused_q),
    .fuse_locked_q(fuse_locked_q), .load_done_q(load_done_q), .overtemp(overtemp),
    .shutdown_q(shutdown_q), .supply_cut_q(supply_cut_q),
    .battery_over_code_q(over_code), .battery_under_code_q(under_code),
    .ignition_on_code_q(ign_code)
  );

  otpcb_fuse_model #(.CYCLES(PC)) fuse_u (
    .clock(clock), .fuse_row_addr_q(fuse_row_addr_q), .burn_q(burn_q), .fuse_row(fuse_row)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_bit(input string what, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Power cycle; the load walk takes exactly four enabled edges
  task automatic power_up;
    reset = 1'b1;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    repeat (3) @(negedge clock);
    chk_bit("load done early", 1'b0, load_done_q);
    chk_byte("fuse row addr", ADDR_LOCK, fuse_row_addr_q);
    @(negedge clock);
    chk_bit("load done", 1'b1, load_done_q);
  endtask

  // Each access ends with an idle cycle so req is never assigned twice in one step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '0;
    @(negedge clock);
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    chk_bit("read valid", 1'b1, reg_rvalid_q);
    chk_byte("read data", exp, reg_rdata_q);
    req = '0;
    @(negedge clock);
  endtask

  // Write then read the same address on back-to-back cycles
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clock);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock);
    chk_bit("read valid", 1'b1, reg_rvalid_q);
    chk_byte("read data", exp, reg_rdata_q);
    req = '0;
    @(negedge clock);
  endtask

  // Request held two cycles: the second one lands while busy and must be refused
  task automatic burn(input logic [7:0] a, input logic [7:0] d);
    int n;
    fuse_prog_req  = 1'b1;
    fuse_prog_addr = a;
    @(negedge clock);
    chk_bit("burn enable", 1'b1, burn_q.en);
    chk_byte("burn addr", a, burn_q.addr);
    chk_byte("burn data", d, burn_q.data);
    n = 1;
    @(negedge clock);
    fuse_prog_req = 1'b0;
    chk_bit("refused while busy", 1'b1, prog_refused_q);
    while (prog_busy_q === 1'b1 && n < 100) begin
      n++;
      @(negedge clock);
    end
    if (n >= 100) begin
      error_cnt++;
      report_and_stop();
    end else begin
      chk_byte("burn length", 8'(PC), 8'(n));
      chk_bit("burn enable off", 1'b0, burn_q.en);
    end
  endtask

  task automatic refuse(input logic [7:0] a);
    fuse_prog_req  = 1'b1;
    fuse_prog_addr = a;
    @(negedge clock);
    fuse_prog_req = 1'b0;
    chk_bit("refused", 1'b1, prog_refused_q);
    chk_bit("no burn", 1'b0, prog_busy_q);
    @(negedge clock);
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    reset          = 1'b1;
    clk_en         = 1'b1;
    req            = '0;
    fuse_prog_req  = 1'b0;
    fuse_prog_addr = 8'h00;
    overtemp       = 1'b0;
    power_up();
    rd_reg(ADDR_OVER, OVER_RESET);
    rd_reg(ADDR_UNDER, UNDER_RESET);
    rd_reg(ADDR_IGN, IGN_RESET);
    rd_reg(8'h10, 8'h00);
    wr_reg(ADDR_IGN, 8'hA5);
    chk_byte("ignition code", 8'h05, {4'h0, ign_code});
    rd_reg(ADDR_IGN, 8'h05);
    wr_rd(ADDR_IGN, 8'h3A, 8'h0A);
    wr_reg(ADDR_OVER, 8'hFF);
    chk_byte("over code", 8'h0F, {4'h0, over_code});
    wr_reg(ADDR_UNDER, 8'h3C);
    chk_byte("under code", 8'h0C, {4'h0, under_code});
    burn(ADDR_OVER, 8'h0F);
    burn(ADDR_UNDER, 8'h0C);
    burn(ADDR_IGN, 8'h0A);
    wr_reg(ADDR_OVER, 8'h07);
    rd_reg(ADDR_OVER, 8'h07);
    chk_byte("over override", 8'h07, {4'h0, over_code});
    wr_reg(ADDR_IGN, 8'h03);
    // Overrides and unburned writes are lost, fused values come back
    power_up();
    rd_reg(ADDR_OVER, 8'h0F);
    rd_reg(ADDR_UNDER, 8'h0C);
    rd_reg(ADDR_IGN, 8'h0A);
    wr_reg(ADDR_LOCK, 8'hFF);
    rd_reg(ADDR_LOCK, 8'h08);
    chk_bit("lock before burn", 1'b0, fuse_locked_q);
    burn(ADDR_LOCK, 8'h08);
    chk_bit("locked", 1'b1, fuse_locked_q);
    refuse(ADDR_IGN);
    power_up();
    chk_bit("lock reloaded", 1'b1, fuse_locked_q);
    refuse(ADDR_OVER);
    overtemp = 1'b1;
    @(negedge clock);
    chk_bit("shutdown", 1'b1, shutdown_q);
    chk_bit("supply cut", 1'b1, supply_cut_q);
    overtemp = 1'b0;
    @(negedge clock);
    chk_bit("shutdown clear", 1'b0, shutdown_q);
    chk_bit("supply back", 1'b0, supply_cut_q);
    report_and_stop();
  end
endmodule // otp_threshold_config_bank_bench
